// >>> uart_pkg.sv
// Constants, field positions and carrier types of the serial port block.
// Assumes an APB master with 32-bit data and byte addresses.
package uart_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses.
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_DIVISOR = 8'h08;
   localparam logic [7:0] ADDR_TX_PORT = 8'h0C;
   localparam logic [7:0] ADDR_RX_PORT = 8'h10;

   // Bit positions in serial_mode_control.
   localparam int M_ON = 15;
   localparam int M_IDLE_HALT = 13;
   localparam int M_IR = 12;
   localparam int M_RTS_SIMPLEX = 11;
   localparam int M_PIN_HI = 9;
   localparam int M_PIN_LO = 8;
   localparam int M_WAKE = 7;
   localparam int M_LOOP = 6;
   localparam int M_RATE_MEAS = 5;
   localparam int M_RX_FLIP = 4;
   localparam int M_FAST = 3;
   localparam int M_PDS_HI = 2;
   localparam int M_PDS_LO = 1;
   localparam int M_STOP2 = 0;

   // Bit positions in serial_status_control.
   localparam int S_TXI_HI = 15;
   localparam int S_TX_FLIP = 14;
   localparam int S_TXI_LO = 13;
   localparam int S_BREAK = 11;
   localparam int S_TX_ON = 10;
   localparam int S_TX_FULL = 9;
   localparam int S_TX_EMPTY = 8;
   localparam int S_RXI_HI = 7;
   localparam int S_RXI_LO = 6;
   localparam int S_ADDR_DET = 5;
   localparam int S_RX_QUIET = 4;
   localparam int S_PAR_FAULT = 3;
   localparam int S_FRM_FAULT = 2;
   localparam int S_OVR_FAULT = 1;
   localparam int S_RX_DATA = 0;

   // Writable bits and reset values.
   localparam logic [15:0] MODE_WR_MASK = 16'hBBFF;
   localparam logic [15:0] STATUS_WR_MASK = 16'hECE0;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] DIVISOR_RESET = 16'h0000;

   // Field encodings.
   localparam logic [1:0] PIN_TXRX = 2'h0;
   localparam logic [1:0] PIN_RTS = 2'h1;
   localparam logic [1:0] PIN_HANDSHAKE = 2'h2;
   localparam logic [1:0] PIN_BCLK = 2'h3;
   localparam logic [1:0] PDS_8N = 2'h0;
   localparam logic [1:0] PDS_8O = 2'h2;
   localparam logic [1:0] PDS_9N = 2'h3;
   localparam logic [1:0] TXI_EACH = 2'h0;
   localparam logic [1:0] TXI_DONE = 2'h1;
   localparam logic [1:0] TXI_EMPTY = 2'h2;
   localparam logic [1:0] RXI_EACH = 2'h0;
   localparam logic [1:0] RXI_FULL = 2'h3;

   // Bit clock and frame timing in ticks and bits.
   localparam logic [3:0] SUB_LAST_STD = 4'hF;
   localparam logic [3:0] SUB_LAST_FAST = 4'h3;
   localparam logic [3:0] SUB_HALF_STD = 4'h7;
   localparam logic [3:0] SUB_HALF_FAST = 4'h1;
   localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
   localparam logic [4:0] FRAME_BASE_LEN = 5'h0A;
   localparam logic [15:0] BREAK_FRAME = 16'hE000;
   localparam logic [4:0] BREAK_LEN = 5'h0E;
   localparam logic [3:0] RX_BITS_BASE = 4'h8;
   localparam logic [2:0] AB_LAST_EDGE = 3'h4;
   localparam logic [4:0] AB_SHIFT_STD = 5'h07;
   localparam logic [4:0] AB_SHIFT_FAST = 5'h05;
   localparam logic [1:0] BUF_FULL = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Carrier types.
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [15:0] sh;
      logic [4:0] len;
   } frame_t;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;

   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] ctl;
      logic ovr;
      logic [15:0] divisor;
      logic [15:0] brg;
      logic rx_s1, rx_s2, rx_s3, rx_v;
      logic cts_s1, cts_s2, cts_s3, cts_v;
      logic [8:0] txf0, txf1;
      logic [1:0] txcnt;
      logic tx_busy, tx_brk;
      logic [15:0] tx_sh;
      logic [4:0] tx_left;
      logic [3:0] tx_sub;
      logic [10:0] rxf0, rxf1;
      logic [1:0] rxcnt;
      rx_state_t rx_st;
      logic [3:0] rx_sub, rx_cnt;
      logic [9:0] rx_sh;
      logic [3:0] ir_hold;
      logic rx_prev, wake_armed;
      logic [2:0] ab_edges;
      logic [23:0] ab_cnt;
      logic rd_pop;
      logic [31:0] prdata;
      logic pready, pslverr;
      logic tx_line, tx_oe, rb_out, rb_oe;
      logic tx_event, rx_event, wake_event;
   } state_t;

   localparam state_t STATE_RESET = '0;

endpackage

// >>> uart_mode_status_control.sv
// Mode, status and data path of an asynchronous serial port with APB access.
// Assumes pins are synchronised here and pin muxing happens outside.
//
// What this block does
// - Module off frees all pins and idles the port; on drives chosen pins.
// - With idle_halt set the port freezes while the device idles.
// - Infrared codec on pulse-encodes tx_line and decodes rx_line.
// - rts_simplex_sel picks simplex or flow control for the request pin.
// - pin_use_sel chooses which pins the port drives and samples.
// - Wake bit watches rx in sleep, flags a fall, clears on rise.
// - Rate measurement times a 55h byte, sets divisor, clears itself.
// - rx_polarity_flip sets the receive idle level low when set.
// - The bit clock gives 4 ticks per bit fast, 16 otherwise.
// - parity_width_sel sets data and parity; stop_count_sel sets stops.
// - tx_irq_sel picks when the transmit event fires.
// - tx_polarity_flip sets transmit idle level, sense swapped by codec.
// - break_send sends start, twelve zeros, stop, then clears itself.
// - Clearing tx_on aborts sending and empties the transmit buffer.
// - tx_buffer_full reads one while both buffer slots are taken.
// - tx_all_empty reads one only when shifter and buffer are empty.
// - rx_irq_sel picks event per character or on buffer full.
// - Address detect with 9-bit frames keeps only address characters.
// - Parity and frame faults belong to the head receive character.
// - Overflow sets overrun; clearing it empties the receive path.
// - rx_has_data shows buffered data; rx_quiet shows an idle receiver.
// - A 16-bit timer sets the bit clock; divisor writes clear it.
// - Reading rx_read_port advances the receive buffer.
`timescale 1ns/1ps

module uart_mode_status_control
   import uart_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire apb_req_t apb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic idle_mode,
   input wire logic sleep_mode,
   input wire logic rx_line,
   input wire logic clear_to_send_in_n,
   output logic tx_line,
   output logic tx_line_oe,
   output logic rts_n_bclk_out,
   output logic rts_n_bclk_oe,
   output logic tx_event,
   output logic rx_event,
   output logic wake_event
);

   ////////////////////////////////////////////////////////////////////////////
   // Access decode and frame building.
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == ADDR_MODE) || (a == ADDR_STATUS) ||
         (a == ADDR_DIVISOR) || (a == ADDR_TX_PORT) || (a == ADDR_RX_PORT);
   endfunction

   function automatic frame_t build_frame(input logic [8:0] dat,
      input logic [1:0] pds, input logic stop2, input logic brk);
      frame_t f;
      f.sh = 16'hFFFF;
      f.len = FRAME_BASE_LEN + {4'h0, stop2} + {4'h0, (pds != PDS_8N)};
      f.sh[0] = 1'b0;
      f.sh[8:1] = dat[7:0];
      if (pds == PDS_9N)
      begin
         f.sh[9] = dat[8];
      end
      else if (pds != PDS_8N)
      begin
         f.sh[9] = (^dat[7:0]) ^ (pds == PDS_8O);
      end
      if (brk)
      begin
         f.sh = BREAK_FRAME;
         f.len = BREAK_LEN;
      end
      build_frame = f;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State and next state.
   state_t q;
   state_t d;
   frame_t fr;
   logic run;
   logic tick;
   logic [3:0] sub_last;
   logic [3:0] sub_half;
   logic [3:0] rx_last;
   logic [1:0] pds;
   logic tx_raw;
   logic rx_in;
   logic rx_bit;
   logic fall;
   logic rise;
   logic cts_ok;
   logic ir_pulse;
   logic keep;
   logic ovr_set;
   logic [9:0] rx_new;
   logic [8:0] rx_dat;
   logic rx_parity_fault;
   logic [23:0] ab_quot;
   logic [15:0] status_word;
   logic [2:0] idx;
   logic [1:0] pin_use;
   logic rts_n;

   always_comb
   begin
      d = q;
      fr = '0;
      keep = 1'b0;
      ovr_set = 1'b0;
      rx_new = '0;
      rx_dat = '0;
      rx_parity_fault = 1'b0;
      ab_quot = '0;
      d.tx_event = 1'b0;
      d.rx_event = 1'b0;
      d.wake_event = 1'b0;
      run = q.mode[M_ON] & ~(q.mode[M_IDLE_HALT] & idle_mode) &
         ~sleep_mode;
      pds = q.mode[M_PDS_HI:M_PDS_LO];
      pin_use = q.mode[M_PIN_HI:M_PIN_LO];
      sub_last = q.mode[M_FAST] ? SUB_LAST_FAST : SUB_LAST_STD;
      sub_half = q.mode[M_FAST] ? SUB_HALF_FAST : SUB_HALF_STD;
      rx_last = RX_BITS_BASE + {3'h0, (pds != PDS_8N)};
      idx = apb.paddr[4:2];

      // Pin synchronisers; a level counts once the last two stages agree.
      d.rx_s1 = rx_line;
      d.rx_s2 = q.rx_s1;
      d.rx_s3 = q.rx_s2;
      if (q.rx_s2 == q.rx_s3)
      begin
         d.rx_v = q.rx_s3;
      end
      d.cts_s1 = clear_to_send_in_n;
      d.cts_s2 = q.cts_s1;
      d.cts_s3 = q.cts_s2;
      if (q.cts_s2 == q.cts_s3)
      begin
         d.cts_v = q.cts_s3;
      end

      // Bit clock timer.
      tick = 1'b0;
      if (run)
      begin
         if (q.brg == q.divisor)
         begin
            d.brg = '0;
            tick = 1'b1;
         end
         else
         begin
            d.brg = q.brg + 16'h0001;
         end
      end

      // Receive input: loopback, polarity and pulse decoder.
      tx_raw = q.tx_busy ? q.tx_sh[0] : 1'b1;
      rx_in = q.mode[M_LOOP] ? tx_raw :
         (q.rx_v ^ q.mode[M_RX_FLIP]);
      rx_bit = rx_in;
      if (q.mode[M_IR])
      begin
         if (!rx_in)
         begin
            d.ir_hold = sub_last;
         end
         else if (tick && (q.ir_hold != 4'h0))
         begin
            d.ir_hold = q.ir_hold - 4'h1;
         end
         rx_bit = rx_in & (q.ir_hold == 4'h0);
      end
      d.rx_prev = rx_bit;
      fall = q.rx_prev & ~rx_bit;
      rise = ~q.rx_prev & rx_bit;

      // Wake on start edge, also while sleeping.
      if (q.mode[M_ON] && q.mode[M_WAKE])
      begin
         if (fall)
         begin
            d.wake_event = 1'b1;
            d.wake_armed = 1'b1;
         end
         else if (rise && q.wake_armed)
         begin
            d.mode[M_WAKE] = 1'b0;
            d.wake_armed = 1'b0;
         end
      end
      else
      begin
         d.wake_armed = 1'b0;
      end

      ////////////////////////////////////////////////////////////////////////
      // Transmitter.
      if (run && q.tx_busy && tick)
      begin
         if (q.tx_sub == sub_last)
         begin
            d.tx_sub = '0;
            d.tx_sh = {1'b1, q.tx_sh[15:1]};
            d.tx_left = q.tx_left - 5'h01;
            if (q.tx_left == 5'h01)
            begin
               d.tx_busy = 1'b0;
               if (q.tx_brk)
               begin
                  d.ctl[S_BREAK] = 1'b0;
               end
               if ({q.ctl[S_TXI_HI], q.ctl[S_TXI_LO]} == TXI_DONE &&
                  q.txcnt == 2'h0)
               begin
                  d.tx_event = 1'b1;
               end
            end
         end
         else
         begin
            d.tx_sub = q.tx_sub + 4'h1;
         end
      end
      cts_ok = !(pin_use == PIN_HANDSHAKE && !q.mode[M_RTS_SIMPLEX] &&
         q.cts_v);
      if (run && !d.tx_busy && q.ctl[S_TX_ON] && d.txcnt != 2'h0 && cts_ok)
      begin
         fr = build_frame(d.txf0, pds, q.mode[M_STOP2],
            d.ctl[S_BREAK]);
         d.tx_brk = d.ctl[S_BREAK];
         d.tx_sh = fr.sh;
         d.tx_left = fr.len;
         d.tx_sub = '0;
         d.tx_busy = 1'b1;
         d.txf0 = d.txf1;
         d.txcnt = d.txcnt - 2'h1;
         if ({q.ctl[S_TXI_HI], q.ctl[S_TXI_LO]} == TXI_EACH ||
            ({q.ctl[S_TXI_HI], q.ctl[S_TXI_LO]} == TXI_EMPTY &&
            d.txcnt == 2'h0))
         begin
            d.tx_event = 1'b1;
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // Receiver.
      if (run)
      begin
         case (q.rx_st)
            RX_IDLE:
            begin
               if (!rx_bit && !q.mode[M_RATE_MEAS])
               begin
                  d.rx_st = RX_START;
                  d.rx_sub = '0;
               end
            end
            RX_START:
            begin
               if (tick && q.rx_sub == sub_half)
               begin
                  d.rx_st = rx_bit ? RX_IDLE : RX_DATA;
                  d.rx_sub = '0;
                  d.rx_cnt = '0;
               end
               else if (tick)
               begin
                  d.rx_sub = q.rx_sub + 4'h1;
               end
            end
            RX_DATA:
            begin
               if (tick && q.rx_sub == sub_last)
               begin
                  d.rx_sub = '0;
                  rx_new = {rx_bit, q.rx_sh[9:1]};
                  d.rx_sh = rx_new;
                  d.rx_cnt = q.rx_cnt + 4'h1;
                  if (q.rx_cnt == rx_last)
                  begin
                     d.rx_st = RX_IDLE;
                     keep = 1'b1;
                  end
               end
               else if (tick)
               begin
                  d.rx_sub = q.rx_sub + 4'h1;
               end
            end
            default:
            begin
               d.rx_st = RX_IDLE;
            end
         endcase
      end
      if (keep)
      begin
         if (pds == PDS_8N)
         begin
            rx_dat = {1'b0, rx_new[8:1]};
         end
         else if (pds == PDS_9N)
         begin
            rx_dat = rx_new[8:0];
         end
         else
         begin
            rx_dat = {1'b0, rx_new[7:0]};
            rx_parity_fault = (^rx_new[8:0]) ^ (pds == PDS_8O);
         end
         keep = !(q.ctl[S_ADDR_DET] && pds == PDS_9N && !rx_dat[8]);
      end
      if (keep && !q.ovr)
      begin
         if (q.rxcnt == BUF_FULL)
         begin
            d.ovr = 1'b1;
            ovr_set = 1'b1;
         end
         else
         begin
            if (q.rxcnt == 2'h0)
            begin
               d.rxf0 = {~rx_new[9], rx_parity_fault, rx_dat};
            end
            else
            begin
               d.rxf1 = {~rx_new[9], rx_parity_fault, rx_dat};
            end
            d.rxcnt = q.rxcnt + 2'h1;
            if ({q.ctl[S_RXI_HI], q.ctl[S_RXI_LO]} == RXI_EACH ||
               ({q.ctl[S_RXI_HI], q.ctl[S_RXI_LO]} == RXI_FULL &&
               d.rxcnt == BUF_FULL))
            begin
               d.rx_event = 1'b1;
            end
         end
      end

      // Rate measurement over eight bit times of the 55h byte.
      if (run && q.mode[M_RATE_MEAS])
      begin
         if (q.ab_edges != 3'h0)
         begin
            d.ab_cnt = q.ab_cnt + 24'h000001;
         end
         if (fall && q.ab_edges == 3'h0)
         begin
            d.ab_cnt = '0;
            d.ab_edges = 3'h1;
         end
         else if (fall && q.ab_edges == AB_LAST_EDGE)
         begin
            ab_quot = (q.ab_cnt + 24'h000001) >>
               (q.mode[M_FAST] ? AB_SHIFT_FAST : AB_SHIFT_STD);
            d.divisor = (ab_quot[15:0] == 16'h0000) ? 16'h0000 :
               ab_quot[15:0] - 16'h0001;
            d.brg = '0;
            d.mode[M_RATE_MEAS] = 1'b0;
            d.ab_edges = '0;
         end
         else if (fall)
         begin
            d.ab_edges = q.ab_edges + 3'h1;
         end
      end
      else
      begin
         d.ab_edges = '0;
      end

      ////////////////////////////////////////////////////////////////////////
      // APB slave: data is prepared in the setup cycle, zero wait states.
      status_word = q.ctl;
      status_word[S_TX_FULL] = (q.txcnt == BUF_FULL);
      status_word[S_TX_EMPTY] = !q.tx_busy && q.txcnt == 2'h0;
      status_word[S_RX_QUIET] = (q.rx_st == RX_IDLE);
      status_word[S_PAR_FAULT] = (q.rxcnt != 2'h0) && q.rxf0[9];
      status_word[S_FRM_FAULT] = (q.rxcnt != 2'h0) && q.rxf0[10];
      status_word[S_OVR_FAULT] = q.ovr;
      status_word[S_RX_DATA] = (q.rxcnt != 2'h0);
      d.pready = 1'b1;
      if (apb.psel && !apb.penable)
      begin
         d.pslverr = !addr_ok(apb.paddr);
         d.rd_pop = 1'b0;
         d.prdata = '0;
         if (!apb.pwrite && addr_ok(apb.paddr))
         begin
            if (idx == ADDR_MODE[4:2])
            begin
               d.prdata = {16'h0000, q.mode};
            end
            else if (idx == ADDR_STATUS[4:2])
            begin
               d.prdata = {16'h0000, status_word};
            end
            else if (idx == ADDR_DIVISOR[4:2])
            begin
               d.prdata = {16'h0000, q.divisor};
            end
            else if (idx == ADDR_RX_PORT[4:2] && q.rxcnt != 2'h0)
            begin
               d.prdata = {23'h000000, q.rxf0[8:0]};
               d.rd_pop = 1'b1;
            end
         end
      end
      if (apb.psel && apb.penable && addr_ok(apb.paddr))
      begin
         if (apb.pwrite && idx == ADDR_MODE[4:2])
         begin
            d.mode = apb.pwdata[15:0] & MODE_WR_MASK;
         end
         else if (apb.pwrite && idx == ADDR_STATUS[4:2])
         begin
            d.ctl = apb.pwdata[15:0] & STATUS_WR_MASK;
            if (q.ctl[S_TX_ON] && !apb.pwdata[S_TX_ON])
            begin
               d.txcnt = '0;
               d.tx_busy = 1'b0;
            end
            if (q.ovr && !apb.pwdata[S_OVR_FAULT] && !ovr_set)
            begin
               d.ovr = 1'b0;
               d.rxcnt = '0;
               d.rx_st = RX_IDLE;
            end
         end
         else if (apb.pwrite && idx == ADDR_DIVISOR[4:2])
         begin
            d.divisor = apb.pwdata[15:0];
            d.brg = '0;
         end
         else if (apb.pwrite && idx == ADDR_TX_PORT[4:2])
         begin
            if (q.mode[M_ON] && d.txcnt != BUF_FULL)
            begin
               if (d.txcnt == 2'h0)
               begin
                  d.txf0 = apb.pwdata[8:0];
               end
               else
               begin
                  d.txf1 = apb.pwdata[8:0];
               end
               d.txcnt = d.txcnt + 2'h1;
            end
         end
         else if (!apb.pwrite && idx == ADDR_RX_PORT[4:2] && q.rd_pop)
         begin
            d.rxf0 = d.rxf1;
            d.rxcnt = d.rxcnt - 2'h1;
         end
      end

      // Module off: everything idle, buffers empty.
      if (!q.mode[M_ON])
      begin
         d.txcnt = '0;
         d.tx_busy = 1'b0;
         d.rxcnt = '0;
         d.rx_st = RX_IDLE;
         d.ovr = 1'b0;
      end

      ////////////////////////////////////////////////////////////////////////
      // Pins.
      ir_pulse = q.tx_busy && !q.tx_sh[0] && (q.tx_sub < IR_PULSE_TICKS);
      d.tx_line = q.mode[M_IR] ? (ir_pulse ^ q.ctl[S_TX_FLIP]) :
         (tx_raw ^ q.ctl[S_TX_FLIP]);
      d.tx_oe = q.mode[M_ON] && q.ctl[S_TX_ON] &&
         !q.mode[M_LOOP];
      rts_n = q.mode[M_RTS_SIMPLEX] ?
         !(q.tx_busy || q.txcnt != 2'h0) : (q.rxcnt == BUF_FULL);
      d.rb_out = (pin_use == PIN_BCLK) ? tick : rts_n;
      d.rb_oe = q.mode[M_ON] && (pin_use != PIN_TXRX);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= STATE_RESET;
      end
      else if (clk_en)
      begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from state.
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign tx_line = q.tx_line;
   assign tx_line_oe = q.tx_oe;
   assign rts_n_bclk_out = q.rb_out;
   assign rts_n_bclk_oe = q.rb_oe;
   assign tx_event = q.tx_event;
   assign rx_event = q.rx_event;
   assign wake_event = q.wake_event;

endmodule

// >>> uart_mode_status_control_monitor.sv
// Checker of the serial port's bus answers and pin enables.
// Assumes one pclk domain; bound to the top module below.
`timescale 1ns/1ps
module uart_mode_status_control_monitor
   import uart_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire apb_req_t apb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_line_oe,
   input wire logic rts_n_bclk_oe,
   input wire logic tx_event,
   input wire logic rx_event,
   input wire logic wake_event
);
   logic on_q;
   logic txon_q;
   logic [1:0] pin_q;
   logic acc;
   assign acc = apb.psel && apb.penable;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         on_q <= 1'b0;
         txon_q <= 1'b0;
         pin_q <= 2'h0;
      end
      else if (acc && apb.pwrite)
      begin
         if (apb.paddr == ADDR_MODE)
         begin
            on_q <= apb.pwdata[M_ON];
            pin_q <= apb.pwdata[M_PIN_HI:M_PIN_LO];
         end
         if (apb.paddr == ADDR_STATUS)
         begin
            txon_q <= apb.pwdata[S_TX_ON];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_off;
      !on_q [*3];
   endsequence
   sequence s_txoff;
      !txon_q [*3];
   endsequence
   a_ready_high: assert property ($past(presetn) |-> pready)
      else $error("pready low after reset");
   a_err_unmapped: assert property (acc && apb.paddr > 8'h10
      |-> pslverr)
      else $error("no error on unmapped access");
   a_ok_mapped: assert property (acc && apb.paddr < 8'h11
      && apb.paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped access");
   a_upper_zero: assert property (acc && !apb.pwrite
      |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   a_tx_pulse: assert property (tx_event |=> !tx_event)
      else $error("transmit event longer than one cycle");
   a_rx_pulse: assert property ($rose(rx_event)
      |=> $fell(rx_event))
      else $error("receive event longer than one cycle");
   a_wake_pulse: assert property (wake_event |=> !wake_event)
      else $error("wake event longer than one cycle");
   a_off_quiet: assert property (s_off
      |-> !tx_line_oe && !rts_n_bclk_oe)
      else $error("pins driven while port off");
   a_txoff_quiet: assert property (s_txoff |-> !tx_line_oe)
      else $error("tx_line driven while transmit off");
   a_pins_txrx: assert property ((on_q && pin_q == PIN_TXRX) [*3]
      |-> !rts_n_bclk_oe)
      else $error("handshake pin driven in two-pin use");
endmodule

bind uart_mode_status_control uart_mode_status_control_monitor i_mon (.pclk,
   .presetn, .apb, .prdata, .pready, .pslverr, .tx_line_oe, .rts_n_bclk_oe,
   .tx_event, .rx_event, .wake_event);

// >>> serial_far_end.sv
// Far transceiver: echoes each sent frame back and always grants sending.
// Assumes a pulled-up line, which idles high whenever it is released.
`timescale 1ns/1ps
module serial_far_end
(
   input wire logic tx_line,
   input wire logic tx_line_oe,
   output logic rx_line,
   output logic clear_to_send_in_n
);
   assign rx_line = tx_line_oe ? tx_line : 1'b1;
   assign clear_to_send_in_n = 1'b0;
endmodule

// >>> uart_mode_status_control_tb.sv
// Self-checking bench: register table, echoed frames, overrun and break.
// Assumes the design answers over APB and a far end that echoes tx_line.
`timescale 1ns/1ps
module uart_mode_status_control_tb
   import uart_pkg::*;
   ;
   typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] e; logic r;} row_t;
   logic pclk, presetn, pready, pslverr, rx_line, cts_n, tx_line, tx_oe;
   logic rts_out, rts_oe, tx_event, rx_event, wake_event, er;
   apb_req_t apb;
   logic [31:0] prdata, rd;
   int n_fail, n_checks, cyc;
   int n_tx, n_rx;
   row_t rows [7] = '{
      '{ADDR_MODE, 16'h3B17, 16'h3B17, 1'b0},
      '{ADDR_MODE, 16'h4400, 16'h0000, 1'b0},
      '{ADDR_DIVISOR, 16'h1234, 16'h1234, 1'b0},
      '{ADDR_DIVISOR, 16'h0000, 16'h0000, 1'b0},
      '{ADDR_STATUS, 16'hE0E0, 16'hE1F0, 1'b0},
      '{ADDR_STATUS, 16'h031F, 16'h0110, 1'b0},
      '{8'h20, 16'hFFFF, 16'h0000, 1'b1}};
   uart_mode_status_control i_uart_mode_status_control (.pclk, .presetn,
      .clk_en(1'b1), .apb, .prdata, .pready, .pslverr, .idle_mode(1'b0),
      .sleep_mode(1'b0), .rx_line, .clear_to_send_in_n(cts_n), .tx_line,
      .tx_line_oe(tx_oe), .rts_n_bclk_out(rts_out), .rts_n_bclk_oe(rts_oe),
      .tx_event, .rx_event, .wake_event);
   serial_far_end i_serial_far_end (.tx_line, .tx_line_oe(tx_oe), .rx_line,
      .clear_to_send_in_n(cts_n));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (n_fail == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      apb <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb.penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
   endtask
   task automatic poll(input int b);
      int k;
      k = 0;
      do
      begin
         xfer(1'b0, ADDR_STATUS, 32'h0);
         k++;
      end
      while (rd[b] !== 1'b1 && k < 400);
   endtask
   task automatic sniff(input logic [15:0] f, input int n);
      @(negedge tx_line);
      for (int i = 0; i < n; i++)
      begin
         repeat (i == 0 ? 8 : 16) @(posedge pclk);
         chk({15'h0, tx_line}, {15'h0, f[i]});
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      n_tx += (tx_event === 1'b1);
      n_rx += (rx_event === 1'b1);
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         end_sim;
      end
   end
   initial
   begin
      apb = '0;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[15:0], 16'h0110);
      foreach (rows[i])
      begin
         xfer(1'b1, rows[i].a, {16'h0, rows[i].w});
         xfer(1'b0, rows[i].a, 32'h0);
         chk(rd[15:0], rows[i].e);
         chk({15'h0, er}, {15'h0, rows[i].r});
      end
      xfer(1'b1, ADDR_MODE, 32'h8000);
      xfer(1'b1, ADDR_STATUS, 32'h0400);
      fork
         sniff(16'h034A, 10);
         xfer(1'b1, ADDR_TX_PORT, 32'hA5);
      join
      poll(S_RX_DATA);
      xfer(1'b0, ADDR_RX_PORT, 32'h0);
      chk(rd[15:0], 16'h00A5);
      chk(n_tx[15:0], 16'h0001);
      chk(n_rx[15:0], 16'h0001);
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[15:0] & 16'h0001, 16'h0000);
      for (int i = 1; i < 4; i++)
         xfer(1'b1, ADDR_TX_PORT, i);
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[15:0] & 16'h0300, 16'h0200);
      poll(S_OVR_FAULT);
      chk(rd[15:0] & 16'h0003, 16'h0003);
      chk({15'h0, rts_out}, 16'h0001);
      xfer(1'b1, ADDR_STATUS, 32'h0400);
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[15:0] & 16'h0003, 16'h0000);
      xfer(1'b1, ADDR_MODE, 32'h8040);
      xfer(1'b1, ADDR_TX_PORT, 32'h3C);
      poll(S_RX_DATA);
      xfer(1'b0, ADDR_RX_PORT, 32'h0);
      chk(rd[15:0], 16'h003C);
      xfer(1'b1, ADDR_MODE, 32'h8000);
      xfer(1'b1, ADDR_STATUS, 32'h0C00);
      fork
         begin
            sniff(16'h2000, 14);
            sniff(16'h02AA, 10);
         end
         begin
            xfer(1'b1, ADDR_TX_PORT, 32'h0);
            xfer(1'b1, ADDR_TX_PORT, 32'h55);
         end
      join
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[15:0] & 16'h0800, 16'h0000);
      xfer(1'b1, ADDR_MODE, 32'h8004);
      fork
         sniff(16'h0402, 11);
         xfer(1'b1, ADDR_TX_PORT, 32'h01);
      join
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[15:0], 16'h0110);
      end_sim;
   end
endmodule
